// file: core/scsb_pkg.sv
package scsb_pkg;

  // sticky flag positions inside the flag vector
  localparam int FLAG_W       = 15;
  localparam int F_PARAM      = 0;
  localparam int F_ADDR       = 1;
  localparam int F_ERASE_SEQ  = 2;
  localparam int F_CMD_CRC    = 3;
  localparam int F_ILLEGAL    = 4;
  localparam int F_ERASE_RST  = 5;
  localparam int F_RANGE      = 6;
  localparam int F_ERASE_PARM = 7;
  localparam int F_WP_VIOL    = 8;
  localparam int F_ECC        = 9;
  localparam int F_CTRL_FAULT = 10;
  localparam int F_GENERAL    = 11;
  localparam int F_ERASE_SKIP = 12;
  localparam int F_LOCK_FAIL  = 13;
  localparam int F_DATA_OVWR  = 14;

  // register byte offsets
  localparam logic [7:0] OFF_EVENT  = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_SEND   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  localparam int         CTRL_BUSY   = 0;
  localparam int         CTRL_LOCKED = 1;
  localparam int         CTRL_IDLE   = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h4;

  localparam int         SEND_FORM_LSB = 0;
  localparam int         SEND_REG_LSB  = 4;
  localparam logic [1:0] FORM_NONE     = 2'h0;
  localparam logic [1:0] FORM_SHORT    = 2'h1;
  localparam logic [1:0] FORM_LONG     = 2'h2;
  localparam logic [1:0] FORM_TOKEN    = 2'h3;
  localparam logic [2:0] REG_NONE      = 3'h0;
  localparam logic [2:0] REG_IDENT     = 3'h3;

  localparam int STAT_ACTIVE   = 16;
  localparam int STAT_GAP_OK   = 17;
  localparam int STAT_SELECTED = 18;
  localparam int STAT_BUSY     = 19;

  // response_clock_gap in serial clocks
  localparam logic [3:0] GAP_CYCLES = 4'h8;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND1, ST_SEND2, ST_BUSY} scsb_state_t;

endpackage : scsb_pkg

// file: core/scsb_shift.sv
`timescale 1ns/1ps
`default_nettype none
module scsb_shift (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  input  wire logic       shift_en,
  output var  logic       bit_out,
  output var  logic       byte_done,
  output var  logic       active
);

  logic [7:0] sreg;
  logic [2:0] cnt;

  assign bit_out = sreg[7];

  // msb first; one bit leaves per serial falling edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sreg      <= 8'hff;
      cnt       <= 3'h0;
      active    <= 1'b0;
      byte_done <= 1'b0;
    end
    else
    begin
      byte_done <= 1'b0;
      if (load)
      begin
        sreg   <= load_byte;
        cnt    <= 3'h7;
        active <= 1'b1;
      end
      else if (active && shift_en)
      begin
        if (cnt == 3'h0)
        begin
          active    <= 1'b0;
          byte_done <= 1'b1;
          sreg      <= 8'hff;
        end
        else
        begin
          sreg <= {sreg[6:0], 1'b1};
          cnt  <= cnt - 3'h1;
        end
      end
    end
  end

endmodule : scsb_shift
`default_nettype wire

// file: core/scsb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module scsb_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output var  logic level_out
);

  logic meta;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta      <= RESET_VAL;
      level_out <= RESET_VAL;
    end
    else
    begin
      meta      <= pin_in;
      level_out <= meta;
    end
  end

endmodule : scsb_sync
`default_nettype wire

// file: core/scsb_top.sv
// Function
// (RULE_01) status goes out as short response, long response or data-error token
// (RULE_02) each error flag clears once the byte carrying it is delivered
// (RULE_03) out-of-range flag, in long response and token, clears on read
// (RULE_04) address-error flag, in both responses, clears on read
// (RULE_05) erase-sequence-error flag, in both responses, clears on read
// (RULE_06) erase-parameter flag, long response only, clears on read
// (RULE_07) parameter-error flag, in both responses, clears on read
// (RULE_08) write-protect-violation flag, long response only, clears on read
// (RULE_09) command crc error flag, in both responses, clears on read
// (RULE_10) illegal-command flag, in both responses, clears on read
// (RULE_11) ecc-failure flag, in long response and token, clears on read
// (RULE_12) controller fault and general error flags, long and token, clear on read
// (RULE_13) erase-skip flag, long response only, clears on read
// (RULE_14) lock-command-failed flag, long response only, clears on read
// (RULE_15) locked flag follows lock state, in long response and token
// (RULE_16) erase-reset flag, in both responses, clears on read
// (RULE_17) idle flag is one from reset until init completes, follows state
// (RULE_18) data-register-overwrite flag, long response only, clears on read
// (RULE_19) only operating-conditions, card-data and identification registers are reachable
// (RULE_20) host keeps clocking response_clock_gap clocks after each response
// (RULE_21) during busy, data out released one clock after select rises
// (RULE_22) on reselect during busy, data out pulled low one clock later
// (RULE_23) busy sends zero bytes; a non-zero byte means ready
`timescale 1ns/1ps
`default_nettype none
module scsb_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  input  wire logic        spi_clk,
  input  wire logic        card_sel_n,
  output var  logic        card_data_out,
  output var  logic        card_data_oe
);

  scsb_pkg::scsb_state_t state;

  logic                      sclk_s;
  logic                      sclk_d;
  logic                      sel_n_s;
  logic                      fall;
  logic                      sh_load;
  logic [7:0]                sh_byte;
  logic                      sh_bit;
  logic                      sh_done;
  logic                      sh_active;
  logic [scsb_pkg::FLAG_W-1:0] flags;
  logic [scsb_pkg::FLAG_W-1:0] set_ev;
  logic [scsb_pkg::FLAG_W-1:0] clr_mask;
  logic [scsb_pkg::FLAG_W-1:0] short_mask;
  logic [scsb_pkg::FLAG_W-1:0] long_mask;
  logic [scsb_pkg::FLAG_W-1:0] token_mask;
  logic [2:0]                ctrl;
  logic [1:0]                form;
  logic [7:0]                short_byte;
  logic [7:0]                long_byte;
  logic [7:0]                token_byte;
  logic                      dp_valid;
  logic                      dp_write;
  logic [7:0]                dp_addr;
  logic                      wr_event;
  logic                      wr_ctrl;
  logic                      wr_send;
  logic                      send_req;
  logic                      bad_reg;
  logic [3:0]                gap_cnt;
  logic                      next_bit;
  logic [31:0]               next_rdata;

  scsb_sync #(
    .RESET_VAL (1'b0)
  ) u_sync_clk (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (spi_clk),
    .level_out (sclk_s)
  );

  scsb_sync #(
    .RESET_VAL (1'b1)
  ) u_sync_sel (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (card_sel_n),
    .level_out (sel_n_s)
  );

  scsb_shift u_shift (
    .clk       (clk),
    .rst       (rst),
    .load      (sh_load),
    .load_byte (sh_byte),
    .shift_en  (fall && !sel_n_s),
    .bit_out   (sh_bit),
    .byte_done (sh_done),
    .active    (sh_active)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
      sclk_d <= 1'b0;
    else
      sclk_d <= sclk_s;
  end

  // card changes its output on the falling serial edge
  assign fall = sclk_d && !sclk_s;

  // bus slave: zero wait states, always okay
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready)
      begin
        dp_valid <= hsel && htrans[1] && (hsize == 3'h2);
        dp_write <= hwrite;
        dp_addr  <= haddr[7:0];
      end
    end
  end

  assign wr_event = dp_valid && dp_write && (dp_addr == scsb_pkg::OFF_EVENT);
  assign wr_ctrl  = dp_valid && dp_write && (dp_addr == scsb_pkg::OFF_CTRL);
  assign wr_send  = dp_valid && dp_write && (dp_addr == scsb_pkg::OFF_SEND);

  // (RULE_19) register access check
  assign bad_reg  = wr_send
                    && (hwdata[scsb_pkg::SEND_REG_LSB +: 3] > scsb_pkg::REG_IDENT);
  assign send_req = wr_send
                    && (hwdata[scsb_pkg::SEND_FORM_LSB +: 2] != scsb_pkg::FORM_NONE);

  // read data registered in the address phase
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      scsb_pkg::OFF_CTRL:
        next_rdata[2:0] = ctrl;
      scsb_pkg::OFF_SEND:
        next_rdata[1:0] = form;
      scsb_pkg::OFF_STATUS:
      begin
        next_rdata[scsb_pkg::FLAG_W-1:0]     = flags;
        next_rdata[scsb_pkg::STAT_ACTIVE]    = (state != scsb_pkg::ST_IDLE);
        next_rdata[scsb_pkg::STAT_GAP_OK]    = (gap_cnt == scsb_pkg::GAP_CYCLES);
        next_rdata[scsb_pkg::STAT_SELECTED]  = !sel_n_s;
        next_rdata[scsb_pkg::STAT_BUSY]      = (state == scsb_pkg::ST_BUSY);
      end
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= next_rdata;
  end

  // (RULE_17) idle starts set, software clears after init
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl <= scsb_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= hwdata[2:0];
  end

  // (RULE_03) per-flag event sources
  always_comb
  begin
    set_ev = '0;
    if (wr_event)
      set_ev = hwdata[scsb_pkg::FLAG_W-1:0];
    if (bad_reg)
      set_ev[scsb_pkg::F_ILLEGAL] = 1'b1;
  end

  // (RULE_04) (RULE_05) (RULE_07) (RULE_09) (RULE_10) short byte layout
  assign short_byte = {1'b0,
                       flags[scsb_pkg::F_PARAM],
                       flags[scsb_pkg::F_ADDR],
                       flags[scsb_pkg::F_ERASE_SEQ],
                       flags[scsb_pkg::F_CMD_CRC],
                       flags[scsb_pkg::F_ILLEGAL],
                       flags[scsb_pkg::F_ERASE_RST],
                       ctrl[scsb_pkg::CTRL_IDLE]};

  // (RULE_06) (RULE_08) (RULE_13) (RULE_14) (RULE_18) long byte, shared bits merge
  assign long_byte  = {flags[scsb_pkg::F_RANGE] | flags[scsb_pkg::F_DATA_OVWR],
                       flags[scsb_pkg::F_ERASE_PARM],
                       flags[scsb_pkg::F_WP_VIOL],
                       flags[scsb_pkg::F_ECC],
                       flags[scsb_pkg::F_CTRL_FAULT],
                       flags[scsb_pkg::F_GENERAL],
                       flags[scsb_pkg::F_ERASE_SKIP] | flags[scsb_pkg::F_LOCK_FAIL],
                       ctrl[scsb_pkg::CTRL_LOCKED]};

  // (RULE_11) (RULE_12) (RULE_15) token, locked is a live bit
  assign token_byte = {3'h0,
                       ctrl[scsb_pkg::CTRL_LOCKED],
                       flags[scsb_pkg::F_RANGE],
                       flags[scsb_pkg::F_ECC],
                       flags[scsb_pkg::F_CTRL_FAULT],
                       flags[scsb_pkg::F_GENERAL]};

  // (RULE_02) flags carried by each form
  always_comb
  begin
    short_mask = '0;
    short_mask[scsb_pkg::F_PARAM]     = 1'b1;
    short_mask[scsb_pkg::F_ADDR]      = 1'b1;
    short_mask[scsb_pkg::F_ERASE_SEQ] = 1'b1;
    short_mask[scsb_pkg::F_CMD_CRC]   = 1'b1;
    short_mask[scsb_pkg::F_ILLEGAL]   = 1'b1;
    short_mask[scsb_pkg::F_ERASE_RST] = 1'b1;
    long_mask = '0;
    long_mask[scsb_pkg::F_RANGE]      = 1'b1;
    long_mask[scsb_pkg::F_DATA_OVWR]  = 1'b1;
    long_mask[scsb_pkg::F_ERASE_PARM] = 1'b1;
    long_mask[scsb_pkg::F_WP_VIOL]    = 1'b1;
    long_mask[scsb_pkg::F_ECC]        = 1'b1;
    long_mask[scsb_pkg::F_CTRL_FAULT] = 1'b1;
    long_mask[scsb_pkg::F_GENERAL]    = 1'b1;
    long_mask[scsb_pkg::F_ERASE_SKIP] = 1'b1;
    long_mask[scsb_pkg::F_LOCK_FAIL]  = 1'b1;
    token_mask = '0;
    token_mask[scsb_pkg::F_RANGE]      = 1'b1;
    token_mask[scsb_pkg::F_ECC]        = 1'b1;
    token_mask[scsb_pkg::F_CTRL_FAULT] = 1'b1;
    token_mask[scsb_pkg::F_GENERAL]    = 1'b1;
  end

  // (RULE_02) clear only what the finished byte carried
  always_comb
  begin
    clr_mask = '0;
    if (sh_done)
    begin
      case (state)
        scsb_pkg::ST_SEND1:
          clr_mask = (form == scsb_pkg::FORM_TOKEN) ? token_mask : short_mask;
        scsb_pkg::ST_SEND2:
          clr_mask = long_mask;
        default:
          clr_mask = '0;
      endcase
    end
  end

  // (RULE_16) sticky error flags, a new event beats the clear
  always_ff @(posedge clk)
  begin
    if (rst)
      flags <= '0;
    else
      flags <= (flags & ~clr_mask) | set_ev;
  end

  // (RULE_01) response sequencing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state   <= scsb_pkg::ST_IDLE;
      form    <= scsb_pkg::FORM_NONE;
      sh_load <= 1'b0;
      sh_byte <= 8'hff;
    end
    else
    begin
      sh_load <= 1'b0;
      case (state)
        scsb_pkg::ST_IDLE:
        begin
          // requests while a response is out are dropped
          if (send_req)
          begin
            form    <= hwdata[scsb_pkg::SEND_FORM_LSB +: 2];
            sh_load <= 1'b1;
            sh_byte <= (hwdata[scsb_pkg::SEND_FORM_LSB +: 2] == scsb_pkg::FORM_TOKEN)
                       ? token_byte : short_byte;
            state   <= scsb_pkg::ST_SEND1;
          end
        end
        scsb_pkg::ST_SEND1:
        begin
          if (sh_done)
          begin
            if (form == scsb_pkg::FORM_LONG)
            begin
              sh_load <= 1'b1;
              sh_byte <= long_byte;
              state   <= scsb_pkg::ST_SEND2;
            end
            else if (form == scsb_pkg::FORM_SHORT && ctrl[scsb_pkg::CTRL_BUSY])
              state <= scsb_pkg::ST_BUSY;
            else
              state <= scsb_pkg::ST_IDLE;
          end
        end
        scsb_pkg::ST_SEND2:
        begin
          if (sh_done)
            state <= scsb_pkg::ST_IDLE;
        end
        scsb_pkg::ST_BUSY:
        begin
          // (RULE_23) leave busy once software drops it
          if (!ctrl[scsb_pkg::CTRL_BUSY])
            state <= scsb_pkg::ST_IDLE;
        end
        default:
          state <= scsb_pkg::ST_IDLE;
      endcase
    end
  end

  // (RULE_20) count host clocks after each response
  always_ff @(posedge clk)
  begin
    if (rst)
      gap_cnt <= scsb_pkg::GAP_CYCLES;
    else if (sh_done)
      gap_cnt <= 4'h0;
    else if (fall && gap_cnt != scsb_pkg::GAP_CYCLES)
      gap_cnt <= gap_cnt + 4'h1;
  end

  // (RULE_23) zeros while busy, ones when nothing is due
  always_comb
  begin
    if (sh_active)
      next_bit = sh_bit;
    else if (state == scsb_pkg::ST_BUSY)
      next_bit = 1'b0;
    else
      next_bit = 1'b1;
  end

  // (RULE_21) release and (RULE_22) resume wait for a serial falling edge
  // the line stays driven if the host stops clocking after deselect
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      card_data_out <= 1'b1;
      card_data_oe  <= 1'b0;
    end
    else if (fall)
    begin
      card_data_oe  <= !sel_n_s;
      card_data_out <= sel_n_s ? 1'b1 : next_bit;
    end
  end

endmodule : scsb_top
`default_nettype wire

// file: dv/scsb_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module scsb_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        spi_clk,
  input wire logic        card_sel_n,
  input wire logic        card_data_out,
  input wire logic        card_data_oe
);
  logic       spi_q;
  logic [3:0] since_fall;
  logic [3:0] since_low;
  // saturating ages of the last serial fall and of the last selected cycle
  always_ff @(posedge clk)
  begin
    spi_q <= spi_clk;
    since_fall <= (spi_q && !spi_clk) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hf};
    since_low <= !card_sel_n ? 4'h0 : since_low + {3'h0, since_low != 4'hf};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  hready_high_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  resp_okay_a: assert property (!hresp)
    else $error("slave answered with an error response");
  idle_high_a: assert property (!card_data_oe |-> card_data_out)
    else $error("released data line not high");
  // synchroniser plus edge detect gives a few cycles of lag
  bit_timing_a: assert property ($changed(card_data_out) |-> since_fall <= 4'h7)
    else $error("data line moved without a serial fall");
  data_release_a: assert property (card_sel_n [*6] ##0 $fell(spi_clk)
    |-> ##[1:7] !card_data_oe)
    else $error("data line not released after deselect");
  busy_resume_a: assert property ($rose(card_data_oe) |-> since_low <= 4'h6)
    else $error("data line driven while not selected");
  unmapped_read_a: assert property (hsel && hready && htrans[1] && !hwrite
    && hsize == 3'h2 && haddr[7:0] >= 8'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  reset_values_a: assert property (disable iff (1'b0) rst
    |=> hrdata == 32'h0 && !card_data_oe)
    else $error("reset values wrong");
  cover property ($rose(card_data_oe));
  cover property ($fell(card_data_oe));
  cover property (hsel && htrans[1] && !hwrite && haddr[7:0] >= 8'h10);
endmodule : scsb_checker

bind scsb_top scsb_checker u_scsb_checker (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .spi_clk(spi_clk),
  .card_sel_n(card_sel_n), .card_data_out(card_data_out), .card_data_oe(card_data_oe));
`default_nettype wire

// file: dv/scsb_host.sv
`timescale 1ns/1ps
`default_nettype none
module scsb_host (
  output var logic spi_clk,
  output var logic card_sel_n,
  input wire logic card_data_out,
  input wire logic card_data_oe
);
  // serial clock stands low outside frames
  initial
  begin
    spi_clk = 1'b0;
    card_sel_n = 1'b1;
  end
  task select(input logic s);
    #7;
    card_sel_n = !s;
    #200;
  endtask : select
  // mode 0; bits are taken late in the period since the card answers through synchronisers
  task xfer(input int n, output logic [15:0] d, output logic all_oe);
    d = 16'h0;
    all_oe = 1'b1;
    #7;
    spi_clk = 1'b1;
    #160;
    repeat (n * 8)
    begin
      spi_clk = 1'b0;
      #160;
      spi_clk = 1'b1;
      #140;
      // a released line floats to its pull-up
      d = {d[14:0], card_data_oe ? card_data_out : 1'b1};
      all_oe = all_oe & card_data_oe;
      #20;
    end
    spi_clk = 1'b0;
    #160;
  endtask : xfer
  task gap;
    #7;
    repeat (8)
    begin
      spi_clk = 1'b1;
      #160;
      spi_clk = 1'b0;
      #160;
    end
  endtask : gap
endmodule : scsb_host
`default_nettype wire

// file: dv/scsb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scsb_top_tb;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        spi_clk, card_sel_n, card_data_out, card_data_oe, oe_ok;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans, f;
  logic [2:0]  hsize, ctl;
  logic [14:0] flg, ev;
  logic [15:0] got;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  assign hready = hreadyout;
  scsb_top u_scsb_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .spi_clk(spi_clk), .card_sel_n(card_sel_n),
    .card_data_out(card_data_out), .card_data_oe(card_data_oe));
  scsb_host u_scsb_host (.spi_clk(spi_clk), .card_sel_n(card_sel_n),
    .card_data_out(card_data_out), .card_data_oe(card_data_oe));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  function logic [15:0] exp_resp(input logic [1:0] fm, input logic [14:0] g, input logic [2:0] c);
    logic [7:0] s;
    logic [7:0] l;
    s = {1'b0, g[0], g[1], g[2], g[3], g[4], g[5], c[2]};
    l = {g[6] | g[14], g[7], g[8], g[9], g[10], g[11], g[12] | g[13], c[1]};
    case (fm)
      2'h1: exp_resp = {8'h0, s};
      2'h2: exp_resp = {s, l};
      default: exp_resp = {11'h0, c[1], g[6], g[9], g[10], g[11]};
    endcase
  endfunction : exp_resp
  function logic [14:0] clr_mask(input logic [1:0] fm);
    clr_mask = (fm == 2'h1) ? 15'h003f : (fm == 2'h2) ? 15'h7fff : 15'h0e40;
  endfunction : clr_mask
  task cmp_reg(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t reg got %h exp %h", $time, g, e);
    end
  endtask : cmp_reg
  task cmp_ser(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t line got %h exp %h", $time, g, e);
    end
  endtask : cmp_ser
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    seed = 32'hadf37638;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, 8'h04, 32'h0, rd);
    cmp_reg(rd, 32'h4);
    ahb(1'b0, 8'h0c, 32'h0, rd);
    cmp_reg(rd & 32'h7fff, 32'h0);
    ahb(1'b0, 8'hfc, 32'h0, rd);
    cmp_reg(rd, 32'h0);
    for (int k = 1; k < 8; k++)
    begin
      ahb(1'b1, 8'h08, 32'(k << 4), rd);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      cmp_reg({31'h0, rd[4]}, {31'h0, k >= 4});
    end
    hsize <= 3'h1;
    ahb(1'b1, 8'h00, 32'h1, rd);
    hsize <= 3'h2;
    ahb(1'b0, 8'h0c, 32'h0, rd);
    cmp_reg({17'h0, rd[14:0]}, 32'h10);
    flg = 15'h0010;
    ctl = 3'h4;
    u_scsb_host.select(1'b1);
    for (int k = 0; k < 9; k++)
    begin
      seed = lfsr(seed);
      ev = (k == 0) ? 15'h7fff : seed[14:0];
      flg = flg | ev;
      ahb(1'b1, 8'h00, {17'h0, ev}, rd);
      if (k > 0)
      begin
        ctl = {seed[20], seed[21], 1'b0};
        ahb(1'b1, 8'h04, {29'h0, ctl}, rd);
      end
      ahb(1'b0, 8'h0c, 32'h0, rd);
      cmp_reg({17'h0, rd[14:0]}, {17'h0, flg});
      f = 2'(k % 3 + 1);
      ahb(1'b1, 8'h08, {30'h0, f}, rd);
      u_scsb_host.xfer((f == 2'h2) ? 2 : 1, got, oe_ok);
      cmp_ser(got, exp_resp(f, flg, ctl));
      cmp_ser({15'h0, oe_ok}, 16'h1);
      u_scsb_host.gap();
      flg = flg & ~clr_mask(f);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      cmp_reg({17'h0, rd[14:0]}, {17'h0, flg});
      cmp_reg({28'h0, rd[19:16]}, 32'h6);
    end
    ahb(1'b1, 8'h04, 32'h1, rd);
    ahb(1'b1, 8'h08, 32'h1, rd);
    u_scsb_host.xfer(2, got, oe_ok);
    cmp_ser(got, exp_resp(2'h1, flg, 3'h1) << 8);
    ahb(1'b0, 8'h0c, 32'h0, rd);
    cmp_reg({28'h0, rd[19:16]}, 32'hf);
    u_scsb_host.select(1'b0);
    u_scsb_host.gap();
    cmp_ser({14'h0, card_data_oe, card_data_out}, 16'h1);
    u_scsb_host.select(1'b1);
    ahb(1'b1, 8'h08, 32'h3, rd);
    u_scsb_host.xfer(1, got, oe_ok);
    cmp_ser({oe_ok, 7'h0, got[7:0]}, 16'h8000);
    ahb(1'b0, 8'h08, 32'h0, rd);
    cmp_reg(rd, 32'h1);
    ahb(1'b1, 8'h04, 32'h0, rd);
    u_scsb_host.xfer(1, got, oe_ok);
    cmp_ser(got, 16'h00ff);
    u_scsb_host.gap();
    u_scsb_host.select(1'b0);
    report_and_stop();
  end
endmodule : scsb_top_tb
`default_nettype wire
